// file: rtl/fcpwm_pkg.sv
package fcpwm_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NUM_CH       = 4;
  localparam int CNT_W        = 16;
  localparam int NUM_MODN     = 11;
  localparam int ADDR_W       = 8;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_GEN_MODE  = 8'h00;
  localparam logic [7:0] OFF_ENABLE    = 8'h04;
  localparam logic [7:0] OFF_STATUS    = 8'h08;
  localparam logic [7:0] OFF_CH_BASE   = 8'h20;
  localparam logic [7:0] OFF_CH_STRIDE = 8'h10;
  localparam logic [7:0] OFF_CH_MODE   = 8'h00;
  localparam logic [7:0] OFF_CH_DUTY   = 8'h04;
  localparam logic [7:0] OFF_CH_PERIOD = 8'h08;
  localparam logic [7:0] OFF_CH_COUNT  = 8'h0c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int POS_DIV_A_RATIO  = 0;
  localparam int POS_DIV_A_SOURCE = 8;
  localparam int POS_DIV_B_RATIO  = 16;
  localparam int POS_DIV_B_SOURCE = 24;
  localparam int POS_CH_CLKSEL    = 0;
  localparam int POS_CH_ALIGN     = 8;
  localparam int POS_CH_POL       = 9;

  // ----------------------------------------------------------------
  // clock select codes and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0]  CLKSEL_DIV_A   = 4'hb;
  localparam logic [3:0]  CLKSEL_DIV_B   = 4'hc;
  localparam logic [31:0] RST_GEN_MODE   = 32'h0000_0000;
  localparam logic [15:0] RST_DUTY       = 16'h0000;
  localparam logic [15:0] RST_PERIOD     = 16'h0000;

  typedef struct packed {
    logic [3:0] b_source;
    logic [7:0] b_ratio;
    logic [3:0] a_source;
    logic [7:0] a_ratio;
  } fcpwm_gen_cfg_t;

  typedef struct packed {
    logic       polarity;
    logic       center;
    logic [3:0] clk_sel;
  } fcpwm_ch_cfg_t;

  typedef struct packed {
    logic              write;
    logic              read;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
  } fcpwm_bus_req_t;

  typedef enum logic [1:0] {
    FCPWM_MODE_IDLE = 2'b00,
    FCPWM_MODE_UP   = 2'b01,
    FCPWM_MODE_DOWN = 2'b10
  } fcpwm_dir_t;

endpackage

// file: rtl/fcpwm_ctrl.sv
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module fcpwm_ctrl
  import fcpwm_pkg::*;
#(
  parameter int N_CH = NUM_CH
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_resetn,
  input  wire logic              i_master_clk_en,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [31:0]       i_wdata,
  input  wire logic              i_write,
  input  wire logic              i_read,
  output logic      [31:0]       o_rdata,
  output logic      [N_CH-1:0]   o_channel_wave_out
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  fcpwm_bus_req_t req;
  assign req = '{write: i_write, read: i_read, addr: i_addr, wdata: i_wdata};

  function automatic logic ch_hit(input logic [ADDR_W-1:0] a, input int ch, input logic [7:0] off);
    ch_hit = (a == 8'(OFF_CH_BASE + 8'(ch) * OFF_CH_STRIDE + off));
  endfunction

  // ----------------------------------------------------------------
  // master clock gate: sync the power-manager enable
  // ----------------------------------------------------------------
  logic mclk_meta_ff;
  logic mclk_en_ff;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      mclk_meta_ff <= 1'b0;
      mclk_en_ff   <= 1'b0;
    end else begin
      mclk_meta_ff <= i_master_clk_en;
      mclk_en_ff   <= mclk_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // generator mode register; writable regardless of clock gate
  // ----------------------------------------------------------------
  fcpwm_gen_cfg_t gen_cfg_ff;
  logic [N_CH-1:0] ch_en_ff;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      gen_cfg_ff <= fcpwm_gen_cfg_t'(RST_GEN_MODE[23:0]);
    end else if (req.write && req.addr == OFF_GEN_MODE) begin
      gen_cfg_ff.a_ratio  <= req.wdata[POS_DIV_A_RATIO +: 8];
      gen_cfg_ff.a_source <= req.wdata[POS_DIV_A_SOURCE +: 4];
      gen_cfg_ff.b_ratio  <= req.wdata[POS_DIV_B_RATIO +: 8];
      gen_cfg_ff.b_source <= req.wdata[POS_DIV_B_SOURCE +: 4];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      ch_en_ff <= '0;
    end else if (req.write && req.addr == OFF_ENABLE) begin
      ch_en_ff <= req.wdata[N_CH-1:0];
    end
  end

  // ----------------------------------------------------------------
  // modulo-n prescaler: ticks are one-cycle enables, not clocks
  // ----------------------------------------------------------------
  logic [NUM_MODN-2:0] prescale_ff;
  logic [NUM_MODN-1:0] modn_tick;

  // counter frozen while gated, so phases resume unchanged
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      prescale_ff <= '0;
    end else if (mclk_en_ff) begin
      prescale_ff <= prescale_ff + 1'b1;
    end
  end

  assign modn_tick[0] = mclk_en_ff;
  for (genvar k = 1; k < NUM_MODN; k++) begin : g_modn
    // tap k fires once every 2**k cycles; off while gated
    assign modn_tick[k] = mclk_en_ff && (prescale_ff[k-1:0] == '1);
  end

  // ----------------------------------------------------------------
  // linear dividers a and b
  // ----------------------------------------------------------------
  logic [7:0] div_a_cnt_ff;
  logic [7:0] div_b_cnt_ff;
  logic       tick_a;
  logic       tick_b;

  function automatic logic src_tick(input logic [NUM_MODN-1:0] t, input logic [3:0] s);
    src_tick = (s < 4'(NUM_MODN)) ? t[s] : 1'b0;
  endfunction

  assign tick_a = (gen_cfg_ff.a_ratio != 8'h00) && src_tick(modn_tick, gen_cfg_ff.a_source)
                  && (div_a_cnt_ff == gen_cfg_ff.a_ratio - 8'h01);
  assign tick_b = (gen_cfg_ff.b_ratio != 8'h00) && src_tick(modn_tick, gen_cfg_ff.b_source)
                  && (div_b_cnt_ff == gen_cfg_ff.b_ratio - 8'h01);

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      div_a_cnt_ff <= 8'h00;
    end else if (gen_cfg_ff.a_ratio == 8'h00) begin
      div_a_cnt_ff <= 8'h00;
    end else if (src_tick(modn_tick, gen_cfg_ff.a_source)) begin
      div_a_cnt_ff <= tick_a ? 8'h00 : div_a_cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      div_b_cnt_ff <= 8'h00;
    end else if (gen_cfg_ff.b_ratio == 8'h00) begin
      div_b_cnt_ff <= 8'h00;
    end else if (src_tick(modn_tick, gen_cfg_ff.b_source)) begin
      div_b_cnt_ff <= tick_b ? 8'h00 : div_b_cnt_ff + 8'h01;
    end
  end

  logic [NUM_MODN+1:0] gen_tick;
  assign gen_tick = {tick_b, tick_a, modn_tick};

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  fcpwm_ch_cfg_t     ch_cfg_ff   [N_CH];
  logic [CNT_W-1:0]  duty_wr_ff  [N_CH];
  logic [CNT_W-1:0]  per_wr_ff   [N_CH];
  logic [CNT_W-1:0]  duty_act_ff [N_CH];
  logic [CNT_W-1:0]  per_act_ff  [N_CH];
  logic [CNT_W-1:0]  cnt_ff      [N_CH];
  fcpwm_dir_t        dir_ff      [N_CH];

  for (genvar c = 0; c < N_CH; c++) begin : g_ch
    logic ch_tick;
    logic at_end;
    logic period_end;
    logic active_level;
    logic start_level;

    assign ch_tick = ch_en_ff[c] &&
                     ((ch_cfg_ff[c].clk_sel <= CLKSEL_DIV_B) ? gen_tick[ch_cfg_ff[c].clk_sel] : 1'b0);
    // left mode wraps one count early so a period is exactly channel_period ticks
    assign at_end  = ch_cfg_ff[c].center ? (cnt_ff[c] >= per_act_ff[c])
                                         : (per_act_ff[c] == 16'h0000 || cnt_ff[c] >= per_act_ff[c] - 16'h0001);
    // center mode closes the period at count 1 on the way down
    assign period_end = ch_cfg_ff[c].center ? (dir_ff[c] == FCPWM_MODE_DOWN && cnt_ff[c] <= 16'h0001)
                                            : at_end;

    // mode register: polarity locked while enabled
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
        ch_cfg_ff[c] <= '0;
      end else if (req.write && ch_hit(req.addr, c, OFF_CH_MODE)) begin
        ch_cfg_ff[c].clk_sel <= req.wdata[POS_CH_CLKSEL +: 4];
        ch_cfg_ff[c].center  <= req.wdata[POS_CH_ALIGN];
        if (!ch_en_ff[c]) begin
          ch_cfg_ff[c].polarity <= req.wdata[POS_CH_POL];
        end
      end
    end

    // software-side copies of duty and period
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
        duty_wr_ff[c] <= RST_DUTY;
        per_wr_ff[c]  <= RST_PERIOD;
      end else begin
        if (req.write && ch_hit(req.addr, c, OFF_CH_DUTY)) begin
          duty_wr_ff[c] <= req.wdata[CNT_W-1:0];
        end
        if (req.write && ch_hit(req.addr, c, OFF_CH_PERIOD)) begin
          per_wr_ff[c] <= req.wdata[CNT_W-1:0];
        end
      end
    end

    // active copies reload only at period boundary or while disabled
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
        duty_act_ff[c] <= RST_DUTY;
        per_act_ff[c]  <= RST_PERIOD;
      end else if (!ch_en_ff[c] || (ch_tick && period_end)) begin
        duty_act_ff[c] <= duty_wr_ff[c];
        per_act_ff[c]  <= per_wr_ff[c];
      end
    end

    // counter advances only on its selected tick
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
        cnt_ff[c] <= '0;
        dir_ff[c] <= FCPWM_MODE_IDLE;
      end else if (!ch_en_ff[c]) begin
        cnt_ff[c] <= '0;
        dir_ff[c] <= FCPWM_MODE_IDLE;
      end else if (ch_tick) begin
        unique case (dir_ff[c])
          FCPWM_MODE_IDLE,
          FCPWM_MODE_UP: begin
            if (at_end && ch_cfg_ff[c].center) begin
              cnt_ff[c] <= cnt_ff[c] - 16'h0001;
              dir_ff[c] <= FCPWM_MODE_DOWN;
            end else if (at_end) begin
              cnt_ff[c] <= '0;
              dir_ff[c] <= FCPWM_MODE_UP;
            end else begin
              cnt_ff[c] <= cnt_ff[c] + 16'h0001;
              dir_ff[c] <= FCPWM_MODE_UP;
            end
          end
          FCPWM_MODE_DOWN: begin
            if (period_end) begin
              cnt_ff[c] <= '0;
              dir_ff[c] <= FCPWM_MODE_UP;
            end else begin
              cnt_ff[c] <= cnt_ff[c] - 16'h0001;
            end
          end
          default: begin
            cnt_ff[c] <= '0;
            dir_ff[c] <= FCPWM_MODE_IDLE;
          end
        endcase
      end
    end

    // start level is polarity; swaps once counter reaches duty, so duty 0
    // is a fixed opposite level; going down it swaps back one count earlier,
    // which keeps the center-aligned high time at twice (period - duty)
    assign start_level  = ch_cfg_ff[c].polarity;
    assign active_level = (dir_ff[c] == FCPWM_MODE_DOWN) ? (cnt_ff[c] > duty_act_ff[c])
                                                         : (cnt_ff[c] >= duty_act_ff[c]);

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
        o_channel_wave_out[c] <= 1'b0;
      end else if (!ch_en_ff[c]) begin
        o_channel_wave_out[c] <= ch_cfg_ff[c].polarity;
      end else if (duty_act_ff[c] == per_act_ff[c]) begin
        o_channel_wave_out[c] <= start_level;
      end else begin
        o_channel_wave_out[c] <= active_level ? ~start_level : start_level;
      end
    end
  end

  // ----------------------------------------------------------------
  // read path: data valid the cycle after the strobe
  // ----------------------------------------------------------------
  logic [31:0] nxt_rdata;

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (req.addr == OFF_GEN_MODE) begin
      nxt_rdata = {4'h0, gen_cfg_ff.b_source, gen_cfg_ff.b_ratio, 4'h0, gen_cfg_ff.a_source, gen_cfg_ff.a_ratio};
    end else if (req.addr == OFF_ENABLE) begin
      nxt_rdata[N_CH-1:0] = ch_en_ff;
    end else if (req.addr == OFF_STATUS) begin
      nxt_rdata[N_CH-1:0] = o_channel_wave_out;
      nxt_rdata[16]       = mclk_en_ff;
    end
    for (int c = 0; c < N_CH; c++) begin
      if (ch_hit(req.addr, c, OFF_CH_MODE)) begin
        nxt_rdata[9:0] = {ch_cfg_ff[c].polarity, ch_cfg_ff[c].center, 4'h0, ch_cfg_ff[c].clk_sel};
      end
      if (ch_hit(req.addr, c, OFF_CH_DUTY)) begin
        nxt_rdata[CNT_W-1:0] = duty_wr_ff[c];
      end
      if (ch_hit(req.addr, c, OFF_CH_PERIOD)) begin
        nxt_rdata[CNT_W-1:0] = per_wr_ff[c];
      end
      if (ch_hit(req.addr, c, OFF_CH_COUNT)) begin
        nxt_rdata[CNT_W-1:0] = cnt_ff[c];
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 32'h0000_0000;
    end else if (req.read) begin
      o_rdata <= nxt_rdata;
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

endmodule

// file: test/fcpwm_ctrl_props.sv
`timescale 1ns/10ps
module fcpwm_ctrl_props
  import fcpwm_pkg::*;
#(
  parameter int N_CH = NUM_CH
) (
  input wire logic              i_clk_sys,
  input wire logic              i_resetn,
  input wire logic              i_master_clk_en,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [31:0]       i_wdata,
  input wire logic              i_write,
  input wire logic              i_read,
  input wire logic [31:0]       o_rdata,
  input wire logic [N_CH-1:0]   o_channel_wave_out
);
  // ----------------------------------------------------------------
  // helper: any write since reset
  // ----------------------------------------------------------------
  logic wr_any_ff;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_any_ff <= 1'b0;
    end else if (i_write) begin
      wr_any_ff <= 1'b1;
    end
  end
  default clocking dclk @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_rdata_idle: assert property (
    $past(i_read) == 1'b0 |-> o_rdata == 32'h0) else $error("read data outside answer cycle");
  a_reset_waves: assert property (
    $rose(i_resetn) |-> o_channel_wave_out == '0) else $error("wave not low after reset");
  a_reset_regs: assert property (
    i_read && i_addr != OFF_STATUS && !wr_any_ff |=> o_rdata == 32'h0) else $error("reset value not zero");
  a_unmapped_read: assert property (
    i_read && (i_addr inside {[8'h0c:8'h1f], [8'h60:8'hff]}) |=> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  // sync of the enable takes two edges, the counter stops on the second and the wave register one edge later, so five idle cycles are just enough
  a_frozen_out: assert property (
    (!i_master_clk_en && !i_write)[*5] |-> $stable(o_channel_wave_out)) else $error("wave moved while stopped");
  a_status_on: assert property (
    (i_master_clk_en[*4] ##0 (i_read && i_addr == OFF_STATUS)) |=> o_rdata[16]) else $error("clock status low");
  a_status_off: assert property (
    (!i_master_clk_en[*4] ##0 (i_read && i_addr == OFF_STATUS)) |=> !o_rdata[16]) else $error("clock status high");
  a_status_wave: assert property (
    i_read && i_addr == OFF_STATUS && $stable(o_channel_wave_out) |=> o_rdata[N_CH-1:0] == $past(o_channel_wave_out))
    else $error("status waves differ");
endmodule

// file: test/fcpwm_load.sv
`timescale 1ns/10ps
module fcpwm_load
  import fcpwm_pkg::*;
(
  input  wire logic                    i_clk_sys,
  input  wire logic [NUM_CH-1:0]       i_wave,
  output logic      [NUM_CH-1:0][15:0] o_period,
  output logic      [NUM_CH-1:0][15:0] o_high
);
  // ----------------------------------------------------------------
  // loads see levels each cycle, no edge latch
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0]       prev_ff;
  logic [NUM_CH-1:0][15:0] cnt_ff;
  logic [NUM_CH-1:0][15:0] hcnt_ff;
  always_ff @(posedge i_clk_sys) begin
    prev_ff <= i_wave;
    for (int c = 0; c < NUM_CH; c++) begin
      if (i_wave[c] && !prev_ff[c]) begin
        o_period[c] <= cnt_ff[c];
        o_high[c]   <= hcnt_ff[c];
        cnt_ff[c]   <= 16'h1;
        hcnt_ff[c]  <= 16'h1;
      end else begin
        cnt_ff[c]  <= cnt_ff[c] + 16'h1;
        hcnt_ff[c] <= hcnt_ff[c] + {15'h0, i_wave[c]};
      end
    end
  end
endmodule

// file: test/tb_fcpwm_ctrl.sv
`timescale 1ns/10ps
module tb_fcpwm_ctrl;
  import fcpwm_pkg::*;
  logic              i_clk_sys = 1'b0;
  logic              i_resetn = 1'b0;
  logic              i_master_clk_en = 1'b0;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [31:0]       i_wdata = '0;
  logic              i_write = 1'b0;
  logic              i_read = 1'b0;
  logic [31:0]       o_rdata;
  logic [3:0]        o_channel_wave_out;
  logic [3:0][15:0]  per;
  logic [3:0][15:0]  hi;
  logic [31:0]       q[$];
  logic              rd_seen = 1'b0;
  logic [31:0]       rv;
  int                n_fail = 0;
  int                checks_done = 0;
  int                seed = 32'h717c;
  always #25 i_clk_sys = ~i_clk_sys;
  fcpwm_ctrl #(.N_CH(NUM_CH)) fcpwm_ctrl_i (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_master_clk_en(i_master_clk_en), .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write),
    .i_read(i_read), .o_rdata(o_rdata), .o_channel_wave_out(o_channel_wave_out));
  fcpwm_load fcpwm_load_i (.i_clk_sys(i_clk_sys), .i_wave(o_channel_wave_out), .o_period(per), .o_high(hi));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic results;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_write <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk_sys);
    q.push_back(exp);
    i_read <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_read <= 1'b0;
  endtask
  function automatic logic [7:0] cb(input int c, input logic [7:0] off);
    return OFF_CH_BASE + OFF_CH_STRIDE * c[7:0] + off;
  endfunction
  function automatic logic [31:0] md(input logic [3:0] s, input logic ctr, input logic pol);
    return {22'h0, pol, ctr, 4'h0, s};
  endfunction
  task automatic cfg(input int c, input logic [31:0] m, input logic [15:0] d, input logic [15:0] p);
    wr(cb(c, OFF_CH_MODE), m);
    wr(cb(c, OFF_CH_DUTY), {16'h0, d});
    wr(cb(c, OFF_CH_PERIOD), {16'h0, p});
  endtask
  task automatic pchk(input int c, input logic [15:0] p, input logic [15:0] h);
    chk({16'h0, per[c]}, {16'h0, p});
    chk({16'h0, hi[c]}, {16'h0, h});
  endtask
  // ----------------------------------------------------------------
  // read monitor: answer stands one cycle after the strobe
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (rd_seen && q.size() > 0) chk(o_rdata, q.pop_front());
    rd_seen <= i_read;
  end
  initial begin
    repeat (100000) @(posedge i_clk_sys);
    n_fail++;
    results();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    rd(OFF_GEN_MODE, RST_GEN_MODE);
    rd(OFF_STATUS, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h7c, 32'h0);
    for (int c = 0; c < 4; c++) begin
      rd(cb(c, OFF_CH_MODE), 32'h0);
      rd(cb(c, OFF_CH_DUTY), {16'h0, RST_DUTY});
      rd(cb(c, OFF_CH_PERIOD), {16'h0, RST_PERIOD});
    end
    // random readback with the master clock still stopped
    for (int k = 0; k < 8; k++) begin
      rv = $random(seed);
      wr(OFF_GEN_MODE, rv);
      rd(OFF_GEN_MODE, rv & 32'h0fff_0fff);
      wr(cb(k % 4, OFF_CH_MODE), rv & 32'h0000_030f);
      rd(cb(k % 4, OFF_CH_MODE), rv & 32'h0000_030f);
      wr(cb(k % 4, OFF_CH_DUTY), rv);
      rd(cb(k % 4, OFF_CH_DUTY), rv & 32'h0000_ffff);
    end
    // divider a from the undivided tap, ratio 3
    wr(OFF_GEN_MODE, 32'h0000_0003);
    cfg(0, md(4'h0, 1'b0, 1'b0), 16'd3, 16'd8);
    cfg(1, md(4'h0, 1'b1, 1'b0), 16'd2, 16'd8);
    cfg(2, md(4'h1, 1'b0, 1'b0), 16'd1, 16'd5);
    cfg(3, md(CLKSEL_DIV_A, 1'b0, 1'b0), 16'd1, 16'd4);
    i_master_clk_en <= 1'b1;
    wr(OFF_ENABLE, 32'hf);
    repeat (100) @(posedge i_clk_sys);
    pchk(0, 16'd8, 16'd5);
    pchk(1, 16'd16, 16'd12);
    pchk(2, 16'd10, 16'd8);
    pchk(3, 16'd12, 16'd9);
    // new period lands at a boundary, never mid-period
    wr(cb(0, OFF_CH_PERIOD), 32'd12);
    repeat (100) @(posedge i_clk_sys);
    pchk(0, 16'd12, 16'd9);
    // stop the master clock, reconfigure, then resume
    i_master_clk_en <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    rv = {28'h0, o_channel_wave_out};
    wr(cb(2, OFF_CH_DUTY), 32'd2);
    rd(cb(2, OFF_CH_DUTY), 32'd2);
    repeat (50) @(posedge i_clk_sys);
    chk({28'h0, o_channel_wave_out}, rv);
    i_master_clk_en <= 1'b1;
    repeat (100) @(posedge i_clk_sys);
    pchk(2, 16'd10, 16'd6);
    // divider b from the /2 tap, ratio 2, on channel 3 alone
    wr(OFF_ENABLE, 32'h0);
    wr(OFF_GEN_MODE, 32'h0102_0003);
    cfg(3, md(CLKSEL_DIV_B, 1'b0, 1'b0), 16'd1, 16'd4);
    wr(OFF_ENABLE, 32'h8);
    repeat (100) @(posedge i_clk_sys);
    pchk(3, 16'd16, 16'd12);
    // fixed levels
    wr(OFF_ENABLE, 32'h0);
    cfg(0, md(4'h0, 1'b0, 1'b0), 16'd6, 16'd6);
    cfg(1, md(4'h0, 1'b0, 1'b0), 16'd0, 16'd6);
    cfg(2, md(4'h0, 1'b0, 1'b1), 16'd0, 16'd6);
    cfg(3, md(4'h0, 1'b0, 1'b1), 16'd6, 16'd6);
    repeat (3) @(posedge i_clk_sys);
    chk({28'h0, o_channel_wave_out}, 32'hc);
    wr(OFF_ENABLE, 32'hf);
    for (int k = 0; k < 10; k++) begin
      repeat (3) @(posedge i_clk_sys);
      chk({28'h0, o_channel_wave_out}, 32'ha);
    end
    rd(OFF_STATUS, 32'h0001_000a);
    // polarity flip while enabled must not show
    wr(cb(0, OFF_CH_MODE), md(4'h0, 1'b0, 1'b1));
    repeat (20) @(posedge i_clk_sys);
    chk({31'h0, o_channel_wave_out[0]}, 32'h0);
    repeat (3) @(posedge i_clk_sys);
    results();
  end
endmodule
bind fcpwm_ctrl fcpwm_ctrl_props #(.N_CH(N_CH)) fcpwm_ctrl_props_i (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
  .i_master_clk_en(i_master_clk_en), .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write),
  .i_read(i_read), .o_rdata(o_rdata), .o_channel_wave_out(o_channel_wave_out));
